// *** quad_pot_pkg.sv ***
// Constants, opcodes and states for the quad potentiometer command unit.
// Assumes a 100 MHz core clock and a 2-wire link sampled on that clock.
//
// Notes on behaviour
// - Stop after a nonvolatile write command starts the internal write cycle.
// - During the write cycle inputs are ignored and the address gets no ack.
// - After the write cycle the slave address is acknowledged again.
// - Instruction byte: opcode high nibble, then pot index, then slot index.
// - 1001 reads wiper, 1010 writes wiper, 1011 reads slot, 1100 writes slot.
// - 1101 slot to wiper, 1110 wiper to slot; 0001 and 1000 do all pots.
// - Opcode 0010 puts the selected pot into step mode.
// - Transfer instructions finish with the instruction byte, no data byte.
// - Slot to wiper loads at once; taps follow after the settle delay.
// - Wiper to slot is a nonvolatile write lasting the write time.
// - Global transfers act on all four pots using the given slot index.
// - Reads and writes take three bytes; the data byte follows the instruction.
// - In step mode a clock pulse with data high steps the wiper up.
// - In step mode a clock pulse with data low steps the wiper down.
// - Wiper is a 6-bit counter decoded one-hot onto sixty-four taps.
// - After reset each wiper loads from its slot zero.
// - Wipers are volatile; all four data slots survive a power cycle. Here rst clears every slot to SLOT_RESET.
// - Each pot has four data slots, readable, writable and transferable.
// - Any data slot change is nonvolatile and ends within 10 ms.
// - Address acks only on type nibble match and all four select pins match.
// - Ack after address, after instruction, and after each received data byte.
// - Data byte: six low bits position, bit 7 cascade, bit 6 wiper disable.
package quad_pot_pkg;
  // ==========================================================================
  // Timing
  localparam int CLK_MHZ      = 100;
  localparam int NV_WRITE_US  = 5000;
  localparam int NV_MAX_US    = 10000;
  localparam int NV_WRITE_CYC = NV_WRITE_US * CLK_MHZ;
  localparam int NV_MAX_CYC   = NV_MAX_US * CLK_MHZ;
  localparam int SETTLE_NS    = 1000;
  localparam int SETTLE_CYC   = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  // ==========================================================================
  // Sizes and fields
  localparam int NUM_POTS    = 4;
  localparam int NUM_SLOTS   = 4;
  localparam int POS_W       = 6;
  localparam int NUM_TAPS    = 64;
  localparam int TYPE_LO     = 4;
  localparam int ADDR_HI     = 3;
  localparam int OPC_LO      = 4;
  localparam int POT_HI      = 3;
  localparam int POT_LO      = 2;
  localparam int SLOT_HI     = 1;
  localparam int CASCADE_BIT = 7;
  localparam int DISABLE_BIT = 6;
  localparam logic [3:0] BIT_CNT_FULL  = 4'h8;
  localparam logic [5:0] POS_MAX       = 6'h3F;
  localparam logic [5:0] POS_MIN       = 6'h00;
  localparam logic [5:0] POS_ONE       = 6'h01;
  localparam logic [7:0] SLOT_RESET    = 8'h00;
  localparam logic [7:0] WIPER_RESET   = 8'h00;
  localparam logic [1:0] POWER_UP_SLOT = 2'h0;
  localparam logic [63:0] TAP_ONE      = 64'h1;
  // ==========================================================================
  // Opcodes
  localparam logic [3:0] OP_RD_WIPER   = 4'h9;
  localparam logic [3:0] OP_WR_WIPER   = 4'hA;
  localparam logic [3:0] OP_RD_SLOT    = 4'hB;
  localparam logic [3:0] OP_WR_SLOT    = 4'hC;
  localparam logic [3:0] OP_SLOT2WIPER = 4'hD;
  localparam logic [3:0] OP_WIPER2SLOT = 4'hE;
  localparam logic [3:0] OP_ALL_S2W    = 4'h1;
  localparam logic [3:0] OP_ALL_W2S    = 4'h8;
  localparam logic [3:0] OP_STEP       = 4'h2;
  // ==========================================================================
  // Link states
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h3,
    ST_INSTR     = 4'h2,
    ST_INSTR_ACK = 4'h6,
    ST_DATA_RX   = 4'h7,
    ST_DATA_ACK  = 4'h5,
    ST_DATA_TX   = 4'h4,
    ST_TX_ACK    = 4'hC,
    ST_STEP      = 4'hD,
    ST_HOLD      = 4'hF
  } link_state_e;
endpackage

// *** bus_events_if.sv ***
// Sampled link events passed from the sampler to the command unit.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface bus_events_if;
  logic       scl_rise;
  logic       scl_fall;
  logic       start;
  logic       stop;
  logic       sda_lvl;
  logic [3:0] addr;
  modport src (output scl_rise, scl_fall, start, stop, sda_lvl, addr);
  modport dst (input scl_rise, scl_fall, start, stop, sda_lvl, addr);
endinterface

// *** serial_sampler.sv ***
// Synchronises the link pins and address pins and finds edges.
// Assumes the pins are asynchronous to core_clk.
`timescale 1ns/1ps
module serial_sampler (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       scl,
  input  wire logic       sda_i,
  input  wire logic [3:0] address_select_pins,
  bus_events_if.src       ev
);
  logic [1:0] scl_sy_r;
  logic [1:0] sda_sy_r;
  logic [3:0] addr_a_r;
  logic [3:0] addr_b_r;
  logic       scl_prev_r;
  logic       sda_prev_r;

  // ==========================================================================
  // Two-stage synchronisers, idle bus reads high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_sy_r   <= 2'h3;
      sda_sy_r   <= 2'h3;
      addr_a_r   <= 4'h0;
      addr_b_r   <= 4'h0;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_sy_r   <= {scl_sy_r[0], scl};
      sda_sy_r   <= {sda_sy_r[0], sda_i};
      addr_a_r   <= address_select_pins;
      addr_b_r   <= addr_a_r;
      scl_prev_r <= scl_sy_r[1];
      sda_prev_r <= sda_sy_r[1];
    end
  end

  // ==========================================================================
  // Edges and start/stop
  assign ev.scl_rise = scl_sy_r[1] & ~scl_prev_r;
  assign ev.scl_fall = ~scl_sy_r[1] & scl_prev_r;
  assign ev.start    = scl_sy_r[1] & scl_prev_r & ~sda_sy_r[1] & sda_prev_r;
  assign ev.stop     = scl_sy_r[1] & scl_prev_r & sda_sy_r[1] & ~sda_prev_r;
  assign ev.sda_lvl  = sda_sy_r[1];
  assign ev.addr     = addr_b_r;
endmodule

// *** quad_pot_cmd_unit.sv ***
// Command decoder, wiper registers and data slots for four pots.
// Assumes a 2-wire master drives scl; sda is open drain with a pull-up.
`timescale 1ns/1ps
module quad_pot_cmd_unit #(
  parameter logic [3:0] DEV_TYPE_ID  = 4'h3, // Arbitrary value
  parameter int         NV_CYC       = quad_pot_pkg::NV_WRITE_CYC,
  parameter int         SETTLE_CYC   = quad_pot_pkg::SETTLE_CYC
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic                     scl,
  input  wire logic                     sda_i,
  output logic                          sda_o,
  output logic                          sda_oe,
  input  wire logic [3:0]               address_select_pins,
  output logic [3:0][63:0]              tap_select,
  output logic [3:0]                    cascade_enable,
  output logic [3:0]                    wiper_disable,
  output logic                          nv_busy
);
  localparam int NP = quad_pot_pkg::NUM_POTS;
  localparam int BW = $clog2(NV_CYC + 1);
  localparam int SW = $clog2(SETTLE_CYC + 1);
  localparam logic [BW-1:0] NV_LAST = BW'(NV_CYC - 1);
  localparam logic [SW-1:0] SETTLE_LAST = SW'(SETTLE_CYC - 1);

  // ==========================================================================
  // Elaboration checks
  if (NV_CYC < 1 || NV_CYC > quad_pot_pkg::NV_MAX_CYC)
    $error("write cycle count out of range");
  if (SETTLE_CYC < 1)
    $error("settle count must be at least one");

  bus_events_if ev ();

  serial_sampler u_sampler (
    .core_clk            (core_clk),
    .rst                 (rst),
    .scl                 (scl),
    .sda_i               (sda_i),
    .address_select_pins (address_select_pins),
    .ev                  (ev.src)
  );

  quad_pot_pkg::link_state_e state_r;
  logic [3:0]      cnt_r;
  logic [7:0]      sr_r;
  logic [7:0]      instr_r;
  logic [7:0]      tx_r;
  logic            sda_oe_r;
  logic            busy_r;
  logic [BW-1:0]   busy_cnt_r;
  logic            init_r;
  logic            step_dir_r;
  logic [NP-1:0]   pend_mask_r;
  logic [1:0]      pend_slot_r;
  logic [7:0]      pend_data_r [NP];
  logic [7:0]      wiper_r [NP];
  logic [7:0]      prev_r [NP];
  logic [7:0]      applied_r [NP];
  logic [SW-1:0]   settle_cnt_r [NP];
  logic [7:0]      slot_r [NP][quad_pot_pkg::NUM_SLOTS];
  logic [NP-1:0][63:0] tap_r;

  logic       fall_full;
  logic       addr_ok;
  logic       op_ok;
  logic       do_instr;
  logic       do_wdata;
  logic       step_ev;
  logic       nv_start;
  logic       nv_done;
  logic [3:0] op;
  logic [1:0] op_pot;
  logic [1:0] op_slot;
  logic [3:0] ins_op;
  logic [1:0] ins_pot;
  logic [1:0] ins_slot;

  // ==========================================================================
  // Decode
  always_comb begin
    fall_full = ev.scl_fall && cnt_r == quad_pot_pkg::BIT_CNT_FULL;
    addr_ok   = sr_r[7:quad_pot_pkg::TYPE_LO] == DEV_TYPE_ID &&
                sr_r[quad_pot_pkg::ADDR_HI:0] == ev.addr;
    op        = sr_r[7:quad_pot_pkg::OPC_LO];
    op_pot    = sr_r[quad_pot_pkg::POT_HI:quad_pot_pkg::POT_LO];
    op_slot   = sr_r[quad_pot_pkg::SLOT_HI:0];
    ins_op    = instr_r[7:quad_pot_pkg::OPC_LO];
    ins_pot   = instr_r[quad_pot_pkg::POT_HI:quad_pot_pkg::POT_LO];
    ins_slot  = instr_r[quad_pot_pkg::SLOT_HI:0];
    op_ok     = op inside {quad_pot_pkg::OP_RD_WIPER,
                           quad_pot_pkg::OP_WR_WIPER,
                           quad_pot_pkg::OP_RD_SLOT,
                           quad_pot_pkg::OP_WR_SLOT,
                           quad_pot_pkg::OP_SLOT2WIPER,
                           quad_pot_pkg::OP_WIPER2SLOT,
                           quad_pot_pkg::OP_ALL_S2W,
                           quad_pot_pkg::OP_ALL_W2S,
                           quad_pot_pkg::OP_STEP};
    do_instr  = state_r == quad_pot_pkg::ST_INSTR && fall_full && op_ok;
    do_wdata  = state_r == quad_pot_pkg::ST_DATA_RX && fall_full;
    step_ev   = state_r == quad_pot_pkg::ST_STEP && ev.scl_fall;
    nv_start  = ev.stop && (|pend_mask_r) && !busy_r;
    nv_done   = busy_r && busy_cnt_r == NV_LAST;
  end

  // ==========================================================================
  // Bit counter and receive shifter, MSB first
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
      sr_r  <= 8'h00;
    end else if (ev.start || fall_full) begin
      cnt_r <= 4'h0;
    end else if (ev.scl_rise && state_r inside {quad_pot_pkg::ST_ADDR,
               quad_pot_pkg::ST_INSTR, quad_pot_pkg::ST_DATA_RX,
               quad_pot_pkg::ST_DATA_TX}) begin
      cnt_r <= cnt_r + 4'h1;
      sr_r  <= {sr_r[6:0], ev.sda_lvl};
    end
  end

  // ==========================================================================
  // Step direction, held from scl rise to the fall
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      step_dir_r <= 1'b0;
    end else if (ev.scl_rise) begin
      step_dir_r <= ev.sda_lvl;
    end
  end

  // ==========================================================================
  // Link state machine
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r  <= quad_pot_pkg::ST_IDLE;
      sda_oe_r <= 1'b0;
      instr_r  <= 8'h00;
      tx_r     <= 8'h00;
    end else if (busy_r) begin
      state_r  <= quad_pot_pkg::ST_IDLE;
      sda_oe_r <= 1'b0;
    end else if (ev.start) begin
      state_r  <= quad_pot_pkg::ST_ADDR;
      sda_oe_r <= 1'b0;
    end else if (ev.stop) begin
      state_r  <= quad_pot_pkg::ST_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      unique case (state_r)
        quad_pot_pkg::ST_IDLE, quad_pot_pkg::ST_STEP,
        quad_pot_pkg::ST_HOLD: begin
        end
        quad_pot_pkg::ST_ADDR: begin
          if (fall_full) begin
            state_r  <= addr_ok ? quad_pot_pkg::ST_ADDR_ACK
                                : quad_pot_pkg::ST_HOLD;
            sda_oe_r <= addr_ok;
          end
        end
        quad_pot_pkg::ST_ADDR_ACK: begin
          if (ev.scl_fall) begin
            state_r  <= quad_pot_pkg::ST_INSTR;
            sda_oe_r <= 1'b0;
          end
        end
        quad_pot_pkg::ST_INSTR: begin
          if (fall_full) begin
            state_r  <= op_ok ? quad_pot_pkg::ST_INSTR_ACK
                              : quad_pot_pkg::ST_HOLD;
            sda_oe_r <= op_ok;
            instr_r  <= sr_r;
          end
        end
        quad_pot_pkg::ST_INSTR_ACK: begin
          if (ev.scl_fall) begin
            sda_oe_r <= 1'b0;
            unique case (ins_op)
              quad_pot_pkg::OP_RD_WIPER: begin
                state_r  <= quad_pot_pkg::ST_DATA_TX;
                tx_r     <= wiper_r[ins_pot];
                sda_oe_r <= ~wiper_r[ins_pot][7];
              end
              quad_pot_pkg::OP_RD_SLOT: begin
                state_r  <= quad_pot_pkg::ST_DATA_TX;
                tx_r     <= slot_r[ins_pot][ins_slot];
                sda_oe_r <= ~slot_r[ins_pot][ins_slot][7];
              end
              quad_pot_pkg::OP_WR_WIPER, quad_pot_pkg::OP_WR_SLOT: begin
                state_r <= quad_pot_pkg::ST_DATA_RX;
              end
              quad_pot_pkg::OP_STEP: begin
                state_r <= quad_pot_pkg::ST_STEP;
              end
              default: begin
                state_r <= quad_pot_pkg::ST_HOLD;
              end
            endcase
          end
        end
        quad_pot_pkg::ST_DATA_RX: begin
          if (fall_full) begin
            state_r  <= quad_pot_pkg::ST_DATA_ACK;
            sda_oe_r <= 1'b1;
          end
        end
        quad_pot_pkg::ST_DATA_ACK: begin
          if (ev.scl_fall) begin
            state_r  <= quad_pot_pkg::ST_HOLD;
            sda_oe_r <= 1'b0;
          end
        end
        quad_pot_pkg::ST_DATA_TX: begin
          if (fall_full) begin
            state_r  <= quad_pot_pkg::ST_TX_ACK;
            sda_oe_r <= 1'b0;
          end else if (ev.scl_fall) begin
            tx_r     <= {tx_r[6:0], 1'b0};
            sda_oe_r <= ~tx_r[6];
          end
        end
        quad_pot_pkg::ST_TX_ACK: begin
          if (ev.scl_fall) begin
            state_r <= quad_pot_pkg::ST_HOLD;
          end
        end
        default: begin
          state_r  <= quad_pot_pkg::ST_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Pending nonvolatile writes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_mask_r <= '0;
      pend_slot_r <= 2'h0;
      for (int i = 0; i < NP; i++) begin
        pend_data_r[i] <= quad_pot_pkg::SLOT_RESET;
      end
    end else if (nv_done) begin
      pend_mask_r <= '0;
    end else if (do_instr && op == quad_pot_pkg::OP_WIPER2SLOT) begin
      pend_mask_r          <= NP'(1) << op_pot;
      pend_slot_r          <= op_slot;
      pend_data_r[op_pot]  <= wiper_r[op_pot];
    end else if (do_instr && op == quad_pot_pkg::OP_ALL_W2S) begin
      pend_mask_r <= '1;
      pend_slot_r <= op_slot;
      for (int i = 0; i < NP; i++) begin
        pend_data_r[i] <= wiper_r[i];
      end
    end else if (do_wdata && ins_op == quad_pot_pkg::OP_WR_SLOT) begin
      pend_mask_r          <= NP'(1) << ins_pot;
      pend_slot_r          <= ins_slot;
      pend_data_r[ins_pot] <= sr_r;
    end
  end

  // ==========================================================================
  // Internal write cycle timer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_r     <= 1'b0;
      busy_cnt_r <= '0;
    end else if (nv_start) begin
      busy_r     <= 1'b1;
      busy_cnt_r <= '0;
    end else if (nv_done) begin
      busy_r     <= 1'b0;
    end else if (busy_r) begin
      busy_cnt_r <= busy_cnt_r + BW'(1);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      init_r <= 1'b1;
    end else begin
      init_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Per-pot wiper, slots and tap drive
  for (genvar p = 0; p < NP; p++) begin : g_pot
    logic [5:0] pos;
    logic       sel;
    assign pos = wiper_r[p][quad_pot_pkg::POS_W-1:0];
    assign sel = ins_pot == 2'(p);

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        wiper_r[p] <= quad_pot_pkg::WIPER_RESET;
      end else if (init_r) begin
        wiper_r[p] <= slot_r[p][quad_pot_pkg::POWER_UP_SLOT];
      end else if (do_instr && (op == quad_pot_pkg::OP_ALL_S2W ||
                   (op == quad_pot_pkg::OP_SLOT2WIPER &&
                    op_pot == 2'(p)))) begin
        wiper_r[p] <= slot_r[p][op_slot];
      end else if (do_wdata && sel &&
                   ins_op == quad_pot_pkg::OP_WR_WIPER) begin
        wiper_r[p] <= sr_r;
      end else if (step_ev && sel) begin
        if (step_dir_r && pos != quad_pot_pkg::POS_MAX) begin
          wiper_r[p][quad_pot_pkg::POS_W-1:0] <=
            pos + quad_pot_pkg::POS_ONE;
        end else if (!step_dir_r && pos != quad_pot_pkg::POS_MIN) begin
          wiper_r[p][quad_pot_pkg::POS_W-1:0] <=
            pos - quad_pot_pkg::POS_ONE;
        end
      end
    end

    for (genvar s = 0; s < quad_pot_pkg::NUM_SLOTS; s++) begin : g_slot
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          slot_r[p][s] <= quad_pot_pkg::SLOT_RESET;
        end else if (nv_done && pend_mask_r[p] &&
                     pend_slot_r == 2'(s)) begin
          slot_r[p][s] <= pend_data_r[p];
        end
      end
    end

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        prev_r[p]       <= quad_pot_pkg::WIPER_RESET;
        applied_r[p]    <= quad_pot_pkg::WIPER_RESET;
        settle_cnt_r[p] <= '0;
        tap_r[p]        <= quad_pot_pkg::TAP_ONE;
      end else begin
        prev_r[p] <= wiper_r[p];
        if (prev_r[p] != wiper_r[p]) begin
          settle_cnt_r[p] <= '0;
        end else if (applied_r[p] != wiper_r[p]) begin
          if (settle_cnt_r[p] == SETTLE_LAST) begin
            settle_cnt_r[p] <= '0;
            applied_r[p]    <= wiper_r[p];
            tap_r[p]        <= quad_pot_pkg::TAP_ONE << pos;
          end else begin
            settle_cnt_r[p] <= settle_cnt_r[p] + SW'(1);
          end
        end
      end
    end

    assign cascade_enable[p] = applied_r[p][quad_pot_pkg::CASCADE_BIT];
    assign wiper_disable[p]  = applied_r[p][quad_pot_pkg::DISABLE_BIT];

    a_tap_onehot: assert property (@(posedge core_clk) disable iff (rst)
      $onehot(tap_r[p])) else $error("tap select not one-hot");
  end

  assign tap_select = tap_r;
  assign sda_oe     = sda_oe_r;
  assign nv_busy    = busy_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_addr_match;
    state_r == quad_pot_pkg::ST_ADDR && fall_full && addr_ok;
  endsequence
  sequence s_ack_slot;
    sda_oe_r [*1] ##1 (state_r == quad_pot_pkg::ST_ADDR_ACK);
  endsequence

  a_busy_no_ack: assert property (busy_r |=> !sda_oe_r)
    else $error("ack driven during write cycle");
  a_addr_ack: assert property (s_addr_match |=> s_ack_slot)
    else $error("matching address not acknowledged");
  a_addr_nomatch: assert property (
    state_r == quad_pot_pkg::ST_ADDR && fall_full && !addr_ok && !busy_r
    |=> !sda_oe_r) else $error("foreign address acknowledged");
  a_nv_starts: assert property (nv_start |=> busy_r && busy_cnt_r == '0)
    else $error("write cycle not started at stop");
  a_nv_length: assert property ($fell(busy_r) |-> $past(busy_cnt_r) == NV_LAST)
    else $error("write cycle length wrong");
  a_nv_commit: assert property (nv_done && pend_mask_r[0] |=>
    slot_r[0][pend_slot_r] == $past(pend_data_r[0]))
    else $error("slot not written at end of cycle");
  a_power_load: assert property ($fell(init_r) |->
    wiper_r[0] == slot_r[0][quad_pot_pkg::POWER_UP_SLOT])
    else $error("wiper not loaded from slot zero");
  a_step_up: assert property (step_ev && step_dir_r &&
    wiper_r[ins_pot][5:0] != quad_pot_pkg::POS_MAX |=>
    wiper_r[ins_pot][5:0] == $past(wiper_r[ins_pot][5:0]) + 6'h01)
    else $error("step up wrong");
  a_step_down: assert property (step_ev && !step_dir_r &&
    wiper_r[ins_pot][5:0] != quad_pot_pkg::POS_MIN |=>
    wiper_r[ins_pot][5:0] == $past(wiper_r[ins_pot][5:0]) - 6'h01)
    else $error("step down wrong");
  a_step_sat: assert property (step_ev && step_dir_r &&
    wiper_r[ins_pot][5:0] == quad_pot_pkg::POS_MAX |=>
    wiper_r[ins_pot][5:0] == quad_pot_pkg::POS_MAX)
    else $error("step wrapped at top");
endmodule

// *** host_model.sv ***
// Behavioural 2-wire bus master for the pot command unit.
// Assumes sda has a pull-up; sda_low high means the master pulls it.
`timescale 1ns/1ps
module host_model (
  output logic     scl,
  output logic     sda_low,
  input  wire logic sda
);
  // ==========================================================================
  // Bit level; clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic bit_io(input logic b, output logic s);
    #10 sda_low = ~b;
    #52.5 scl = 1'b1;
    #31 s = sda;
    #31.5 scl = 1'b0;
  endtask
  task automatic start;
    #10 sda_low = 1'b0;
    #52.5 scl = 1'b1;
    #31 sda_low = 1'b1;
    #31.5 scl = 1'b0;
  endtask
  task automatic stop;
    #10 sda_low = 1'b1;
    #52.5 scl = 1'b1;
    #31 sda_low = 1'b0;
    #31.5;
  endtask
  // ==========================================================================
  // Byte level
  task automatic wr(input logic [7:0] d, output logic ak);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ak = ~s;
  endtask
  task automatic rd(output logic [7:0] d, input logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(nak, s);
  endtask
endmodule

// *** tb_quad_pot_cmd_unit.sv ***
// Self-checking bench for the quad pot command unit.
// Assumes host_model as the bus master and a pull-up on sda.
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  mismatches++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb_quad_pot_cmd_unit;
  logic             core_clk = 1'b0;
  logic             rst = 1'b1;
  logic [3:0]       pins = 4'h0;
  wire              scl;
  wire              m_low;
  wire              sda_o;
  wire              sda_oe;
  wire              nv_busy;
  wire [3:0][63:0]  taps;
  wire [3:0]        casc;
  wire [3:0]        wdis;
  wire              sda = ~(m_low | sda_oe);
  int               mismatches = 0;
  int               tests_run = 0;
  int               cyc = 0;
  logic [31:0]      lf = 32'hE572;
  logic             a;
  logic [7:0]       r;
  logic [7:0]       d;
  always #5 core_clk = ~core_clk;
  quad_pot_cmd_unit #(.DEV_TYPE_ID(4'h3), .NV_CYC(200), .SETTLE_CYC(4))
    quad_pot_cmd_unit_inst (
    .core_clk(core_clk), .rst(rst), .scl(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .address_select_pins(pins), .tap_select(taps),
    .cascade_enable(casc), .wiper_disable(wdis), .nv_busy(nv_busy));
  host_model host_model_inst (.scl(scl), .sda_low(m_low), .sda(sda));
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic cmd(input logic [7:0] ins, output logic ak);
    host_model_inst.start();
    host_model_inst.wr({4'h3, pins}, ak);
    `CHK("addr ack", 1'b1, ak)
    host_model_inst.wr(ins, ak);
  endtask
  task automatic rdb(input logic [7:0] ins, output logic [7:0] v);
    cmd(ins, a);
    host_model_inst.rd(v, 1'b1);
    host_model_inst.stop();
  endtask
  task automatic poll;
    int n;
    n = 0;
    #60 `CHK("busy", 1'b1, nv_busy)
    do begin
      host_model_inst.start();
      host_model_inst.wr({4'h3, pins}, a);
      if (n == 0) `CHK("poll nak", 1'b0, a)
      n++;
    end while (a !== 1'b1 && n < 40);
    `CHK("poll ack", 1'b1, a)
    host_model_inst.stop();
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      final_report();
    end
  end
  // ==========================================================================
  // Scenarios
  initial begin
    repeat (2) @(posedge core_clk);
    lf = nx(lf);
    rst <= 1'b0;
    pins <= lf[3:0];
    repeat (6) @(posedge core_clk);
    host_model_inst.start();
    host_model_inst.wr({4'h3, ~pins}, a);
    `CHK("bad addr", 1'b0, a)
    `CHK("sda_o", 1'b0, sda_o)
    host_model_inst.stop();
    $display("test address done");
    for (int p = 0; p < 4; p++) begin
      lf = nx(lf);
      d = lf[7:0];
      cmd({4'hA, p[1:0], 2'h0}, a);
      host_model_inst.wr(d, a);
      `CHK("data ack", 1'b1, a)
      host_model_inst.stop();
      rdb({4'h9, p[1:0], 2'h3}, r);
      `CHK("wiper", d, r)
      `CHK("tap", 64'h1 << d[5:0], taps[p])
      `CHK("ctl", d[7:6], {casc[p], wdis[p]})
    end
    $display("test wiper done");
    lf = nx(lf);
    d = lf[7:0];
    cmd(8'hC6, a);
    host_model_inst.wr(d, a);
    host_model_inst.stop();
    poll();
    rdb(8'hB6, r);
    `CHK("slot", d, r)
    cmd(8'hD6, a);
    `CHK("xfr ack", 1'b1, a)
    host_model_inst.stop();
    rdb(8'h94, r);
    `CHK("xfr", d, r)
    $display("test slot done");
    cmd(8'hA0, a);
    host_model_inst.wr(8'h3E, a);
    host_model_inst.stop();
    cmd(8'h20, a);
    repeat (3) host_model_inst.bit_io(1'b1, a);
    repeat (2) host_model_inst.bit_io(1'b0, a);
    host_model_inst.stop();
    rdb(8'h90, r);
    `CHK("step", 8'h3D, r)
    cmd(8'h81, a);
    host_model_inst.stop();
    poll();
    rdb(8'hB1, r);
    `CHK("global", 8'h3D, r)
    cmd(8'h30, a);
    `CHK("bad op", 1'b0, a)
    host_model_inst.stop();
    $display("test step done");
    final_report();
  end
endmodule
